// File: rtl/bor_ctrl.sv
// Brown-out reset control logic
`timescale 1ns/10ps
module bor_ctrl
  import bor_pkg::*;
#(
  parameter int WARMUP_CYC = BOR_WARMUP_CYC,
  parameter int FILTER_CYC = BOR_FILTER_CYC,
  parameter int POWERUP_TIMER_CYC = BOR_POWERUP_TIMER_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  // Register port
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // System events
  input wire logic SLEEP_REQ_IN,
  input wire logic WAKE_IN,
  input wire logic BULK_ERASE_IN,
  input wire logic SUPPLY_LOW_IN,
  input wire logic LP_BROWNOUT_IN,
  // Results
  output logic BROWNOUT_RESET_OUT,
  output logic RESET_HOLD_OUT,
  output logic RUN_OUT,
  output logic ERASE_ABORT_OUT,
  output logic DETECTOR_ON_OUT,
  output logic [1:0] LEVEL_SEL_OUT
);
  bor_regs_type q, d;
  logic det_on, armed, gate_ok, tripped, low_now;
  logic [1:0] lvl;

  always_comb begin
    d = q;
    d.trip_s1 = SUPPLY_LOW_IN;
    d.trip_s2 = q.trip_s1;
    // Detector power per mode and sleep state
    case (q.cfg.mode)
      BOR_MODE_ON: det_on = 1'b1;
      // Wake request powers it up, else ready could never rebuild in sleep
      BOR_MODE_NOSLEEP: det_on = (q.st != ST_SLEEP) | WAKE_IN;
      BOR_MODE_SW: det_on = q.sw_en;
      default: det_on = 1'b0;
    endcase
    det_on = det_on | BULK_ERASE_IN;
    lvl = BULK_ERASE_IN ? BOR_LEVEL_ERASE : q.cfg.level;
    // Warm-up: ready drops at once when the detector goes off
    if (!det_on) begin
      d.warm_cnt = 16'h0000;
      d.ready = 1'b0;
    end else if (q.warm_cnt >= 16'(WARMUP_CYC - 1)) begin
      d.ready = 1'b1;
    end else begin
      d.warm_cnt = q.warm_cnt + 16'h0001;
    end
    armed = det_on & q.ready;
    low_now = armed & q.trip_s2;
    // Filter rejects dips no longer than the filter time
    if (!low_now) begin
      d.filt_cnt = 16'h0000;
    end else if (q.filt_cnt < 16'(FILTER_CYC)) begin
      d.filt_cnt = q.filt_cnt + 16'h0001;
    end
    tripped = low_now & (q.filt_cnt >= 16'(FILTER_CYC));
    // Erase brown-out aborts instead of resetting
    d.erase_abort = tripped & BULK_ERASE_IN;
    d.bor_rst = (tripped & !BULK_ERASE_IN) | LP_BROWNOUT_IN;
    // Start-up gating: only the two hardware modes wait
    if (q.cfg.mode == BOR_MODE_ON || q.cfg.mode == BOR_MODE_NOSLEEP) begin
      gate_ok = q.ready & !q.trip_s2;
    end else begin
      gate_ok = 1'b1;
    end
    case (q.st)
      ST_HOLD: begin
        d.powerup_timer_cnt = 16'h0000;
        if (gate_ok) begin
          d.st = q.cfg.powerup_timer_en ? ST_POWERUP_TIMER : ST_RUN;
        end
      end
      ST_POWERUP_TIMER: begin
        if (q.powerup_timer_cnt >= 16'(POWERUP_TIMER_CYC - 1)) begin
          d.st = ST_RUN;
        end else begin
          d.powerup_timer_cnt = q.powerup_timer_cnt + 16'h0001;
        end
      end
      ST_RUN: begin
        if (SLEEP_REQ_IN) begin
          d.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Only off-in-sleep mode waits for ready on wake
        if (WAKE_IN && (q.cfg.mode != BOR_MODE_NOSLEEP || q.ready)) begin
          d.st = ST_RUN;
        end
      end
      default: d.st = ST_HOLD;
    endcase
    if (d.bor_rst) begin
      d.st = ST_HOLD;
    end
    // Register writes; the config register is its own choice of place
    if (WR_IN) begin
      if (ADDR_IN == BOR_ADDR_CONTROL) begin
        d.sw_en = WDATA_IN[BOR_SW_EN_BIT];
      end else if (ADDR_IN == BOR_ADDR_CONFIG) begin
        d.cfg.mode = WDATA_IN[BOR_CFG_MODE_LSB +: 2];
        d.cfg.level = WDATA_IN[BOR_CFG_LEVEL_LSB +: 2];
        d.cfg.powerup_timer_en = WDATA_IN[BOR_CFG_POWERUP_TIMER_BIT];
      end
    end
    d.rdata = 8'h00;
    if (RD_IN) begin
      if (ADDR_IN == BOR_ADDR_CONTROL) begin
        d.rdata[BOR_SW_EN_BIT] = q.sw_en;
        d.rdata[BOR_READY_BIT] = q.ready;
      end else if (ADDR_IN == BOR_ADDR_CONFIG) begin
        d.rdata[BOR_CFG_MODE_LSB +: 2] = q.cfg.mode;
        d.rdata[BOR_CFG_LEVEL_LSB +: 2] = q.cfg.level;
        d.rdata[BOR_CFG_POWERUP_TIMER_BIT] = q.cfg.powerup_timer_en;
      end else if (ADDR_IN == BOR_ADDR_STATUS) begin
        d.rdata[3:0] = q.st;
      end
    end
    d.reset_req = (d.st == ST_HOLD) | (d.st == ST_POWERUP_TIMER);
    d.run = (d.st == ST_RUN);
    d.det_on = det_on;
    d.lvl = lvl;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      // Reset models power-on and brown-out; sw enable returns to one
      q <= '0;
      q.st <= ST_HOLD;
      q.sw_en <= BOR_SW_EN_RESET;
      q.reset_req <= 1'b1;
    end else if (CLK_EN_IN) begin
      q <= d;
    end
  end

  assign RDATA_OUT = q.rdata;
  assign BROWNOUT_RESET_OUT = q.bor_rst;
  assign RESET_HOLD_OUT = q.reset_req;
  assign RUN_OUT = q.run;
  assign ERASE_ABORT_OUT = q.erase_abort;
  assign DETECTOR_ON_OUT = q.det_on;
  assign LEVEL_SEL_OUT = q.lvl;
endmodule

// File: common/bor_pkg.sv
// Constants and types for the brown-out reset control block
package bor_pkg;
  // Mode field encodings
  localparam logic [1:0] BOR_MODE_OFF = 2'h0;
  localparam logic [1:0] BOR_MODE_SW = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON = 2'h3;
  // Register map
  localparam logic [3:0] BOR_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] BOR_ADDR_CONFIG = 4'h1;
  localparam logic [3:0] BOR_ADDR_STATUS = 4'h2;
  localparam int BOR_SW_EN_BIT = 7;
  localparam int BOR_READY_BIT = 0;
  localparam logic BOR_SW_EN_RESET = 1'b1;
  // Config register fields
  localparam int BOR_CFG_MODE_LSB = 0;
  localparam int BOR_CFG_LEVEL_LSB = 2;
  localparam int BOR_CFG_POWERUP_TIMER_BIT = 4;
  localparam logic [1:0] BOR_LEVEL_ERASE = 2'h3;
  // Timing at 50 MHz
  localparam int BOR_CLK_MHZ = 50;
  localparam int BOR_WARMUP_US = 10;
  localparam int BOR_FILTER_US = 1;
  localparam int BOR_POWERUP_TIMER_US = 64;
  localparam int BOR_WARMUP_CYC = BOR_WARMUP_US * BOR_CLK_MHZ;
  localparam int BOR_FILTER_CYC = BOR_FILTER_US * BOR_CLK_MHZ;
  localparam int BOR_POWERUP_TIMER_CYC = BOR_POWERUP_TIMER_US * BOR_CLK_MHZ;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_POWERUP_TIMER = 4'h2,
    ST_RUN = 4'h4,
    ST_SLEEP = 4'h8
  } bor_state_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] level;
    logic powerup_timer_en;
  } bor_cfg_type;

  typedef struct packed {
    bor_state_type st;
    bor_cfg_type cfg;
    logic sw_en;
    logic ready;
    logic [15:0] warm_cnt;
    logic [15:0] filt_cnt;
    logic [15:0] powerup_timer_cnt;
    logic trip_s1;
    logic trip_s2;
    logic bor_rst;
    logic reset_req;
    logic erase_abort;
    logic run;
    logic det_on;
    logic [1:0] lvl;
    logic [7:0] rdata;
  } bor_regs_type;
endpackage

// File: sim/bor_ctrl_properties.sv
// Port assertions for the brown-out control block
`timescale 1ns/10ps
module bor_ctrl_properties
  import bor_pkg::*;
(
  // Clock, reset, bus
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  // Events, results
  input wire logic BULK_ERASE_IN,
  input wire logic LP_BROWNOUT_IN,
  input wire logic BROWNOUT_RESET_OUT,
  input wire logic RESET_HOLD_OUT,
  input wire logic RUN_OUT,
  input wire logic DETECTOR_ON_OUT,
  input wire logic [1:0] LEVEL_SEL_OUT
);
  logic [1:0] mode_q;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  // Shadow copy, since the mode field is no port
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN)
      mode_q <= BOR_MODE_OFF;
    else if (WR_IN && CLK_EN_IN && ADDR_IN == BOR_ADDR_CONFIG)
      mode_q <= WDATA_IN[1:0];
  end
  sequence s_erase;
    (BULK_ERASE_IN && !LP_BROWNOUT_IN)[*2];
  endsequence
  property p_pad;
    $past(RD_IN) && $past(ADDR_IN) == BOR_ADDR_CONTROL |-> RDATA_OUT[6:1] == 6'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("pad bits set");
  property p_lvl;
    CLK_EN_IN && BULK_ERASE_IN |=> LEVEL_SEL_OUT == BOR_LEVEL_ERASE;
  endproperty
  a_lvl: assert property (p_lvl) else $error("erase level wrong");
  property p_det;
    BULK_ERASE_IN[*2] |-> DETECTOR_ON_OUT;
  endproperty
  a_det: assert property (p_det) else $error("detector off in erase");
  property p_quiet;
    s_erase |-> !BROWNOUT_RESET_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset in erase");
  property p_lp;
    CLK_EN_IN && LP_BROWNOUT_IN |=> BROWNOUT_RESET_OUT;
  endproperty
  a_lp: assert property (p_lp) else $error("low power request lost");
  property p_hold;
    RESET_HOLD_OUT |-> !RUN_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("run while held");
  property p_on;
    (mode_q == BOR_MODE_ON)[*3] |-> DETECTOR_ON_OUT;
  endproperty
  a_on: assert property (p_on) else $error("detector off in mode on");
  property p_rel;
    $fell(RESET_IN) |-> RESET_HOLD_OUT && !RUN_OUT;
  endproperty
  a_rel: assert property (p_rel) else $error("no hold at release");
endmodule
bind bor_ctrl bor_ctrl_properties u_props (.*);

// File: sim/bor_ctrl_tb.sv
// Self-checking bench for the brown-out control block
`timescale 1ns/10ps
`define C(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t %h %h", $time, g, e); end end
`define WT(c, n) begin for (int i = 0; i < (n) && !(c); i++) tk(1, 1); \
  `C(c, 1'b1) if ((c) !== 1'b1) summarize; end
module bor_ctrl_tb;
  import bor_pkg::*;
  localparam int W = 4;
  localparam int F = 2;
  localparam int P = 8;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [1:0] l;
  } bor_row_type;
  bor_row_type rows [6] = '{'{4'h0, 8'hff, 8'h80, 2'h0}, '{4'h0, 8'h7e, 8'h00, 2'h0},
    '{4'h1, 8'h04, 8'h00, 2'h1}, '{4'h1, 8'h0c, 8'h00, 2'h3}, '{4'hf, 8'haa, 8'h00, 2'h3},
    '{4'h1, 8'h00, 8'h00, 2'h0}};
  logic CLK_SYS_IN = 1'b0, RESET_IN = 1'b1, CLK_EN_IN = 1'b1, WR_IN = 1'b0, RD_IN = 1'b0;
  logic SLEEP_REQ_IN = 1'b0, WAKE_IN = 1'b0, BULK_ERASE_IN = 1'b0, SUPPLY_LOW_IN = 1'b0;
  logic LP_BROWNOUT_IN = 1'b0;
  logic [3:0] ADDR_IN = 4'h0;
  logic [7:0] WDATA_IN = 8'h00, RDATA_OUT, v;
  logic [1:0] LEVEL_SEL_OUT;
  logic BROWNOUT_RESET_OUT, RESET_HOLD_OUT, RUN_OUT, ERASE_ABORT_OUT, DETECTOR_ON_OUT;
  int n_fail = 0, checks = 0;
  bor_ctrl #(.WARMUP_CYC(W), .FILTER_CYC(F), .POWERUP_TIMER_CYC(P)) uut (.*);
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  task automatic tk(int n = 1, bit s = 0);
    repeat (n) @(posedge CLK_SYS_IN);
    if (s) #1;
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One strobe, read data taken in the following cycle
  task automatic acc(bit w, logic [3:0] a, logic [7:0] d = 8'h00);
    tk;
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= w;
    RD_IN <= !w;
    tk;
    WR_IN <= 1'b0;
    RD_IN <= 1'b0;
    #1 v = RDATA_OUT;
  endtask
  task automatic nap;
    tk;
    SLEEP_REQ_IN <= 1'b1;
    tk;
    SLEEP_REQ_IN <= 1'b0;
    `WT(!RUN_OUT, 4)
  endtask
  initial begin
    repeat (2) begin
      tk;
      RESET_IN <= 1'b1;
      tk(5);
      RESET_IN <= 1'b0;
      acc(0, 4'h0);
      `C(v, 8'h80)
      `WT(RUN_OUT, 4)
      foreach (rows[k]) begin
        acc(1, rows[k].a, rows[k].d);
        if (rows[k].a != 4'h1)
          acc(0, rows[k].a);
        if (rows[k].a != 4'h1) `C(v, rows[k].r)
        tk(1, 1);
        `C(LEVEL_SEL_OUT, rows[k].l)
        `C(DETECTOR_ON_OUT, 1'b0)
      end
    end
    acc(1, 4'h1, 8'h03);
    tk(W + 4);
    acc(0, 4'h0);
    `C(v[0], 1'b1)
    // A dip no longer than the filter must pass unseen
    tk;
    SUPPLY_LOW_IN <= 1'b1;
    tk(F);
    SUPPLY_LOW_IN <= 1'b0;
    repeat (6) begin
      tk(1, 1);
      `C(BROWNOUT_RESET_OUT, 1'b0)
    end
    tk;
    SUPPLY_LOW_IN <= 1'b1;
    `WT(BROWNOUT_RESET_OUT, F + 6)
    tk(6, 1);
    `C(RUN_OUT, 1'b0)
    tk;
    SUPPLY_LOW_IN <= 1'b0;
    `WT(RUN_OUT, W + 12)
    nap;
    tk;
    WAKE_IN <= 1'b1;
    `WT(RUN_OUT, 3)
    tk;
    WAKE_IN <= 1'b0;
    acc(1, 4'h1, 8'h02);
    nap;
    `WT(!DETECTOR_ON_OUT, 4)
    tk;
    WAKE_IN <= 1'b1;
    tk(2, 1);
    `C(RUN_OUT, 1'b0)
    `WT(RUN_OUT, W + 8)
    tk;
    WAKE_IN <= 1'b0;
    BULK_ERASE_IN <= 1'b1;
    SUPPLY_LOW_IN <= 1'b1;
    `WT(ERASE_ABORT_OUT, F + 8)
    `C(LEVEL_SEL_OUT, BOR_LEVEL_ERASE)
    `C(BROWNOUT_RESET_OUT, 1'b0)
    tk;
    SUPPLY_LOW_IN <= 1'b0;
    tk(4);
    BULK_ERASE_IN <= 1'b0;
    acc(1, 4'h1, 8'h10);
    tk;
    LP_BROWNOUT_IN <= 1'b1;
    tk;
    LP_BROWNOUT_IN <= 1'b0;
    tk(4, 1);
    `C(RESET_HOLD_OUT, 1'b1)
    `C(RUN_OUT, 1'b0)
    `WT(RUN_OUT, P + 6)
    tk(4);
    summarize;
  end
endmodule
